// ### design/start_guard_params.svh
/*
  constants for the start guard: terminal option codes, error codes, widths.
  assumes inclusion by bare name from design and verif files.
*/
`ifndef START_GUARD_PARAMS_SVH
`define START_GUARD_PARAMS_SVH
`define SG_TERMINAL_COUNT      8
`define SG_OPTION_WIDTH        8
`define SG_GUARD_OPTION        8'h0D
`define SG_EXT_TRIP_OPTION     8'h0C
`define SG_ERR_WIDTH           8
`define SG_ERR_NONE            8'h00
`define SG_ERR_UNDERVOLTAGE    8'h09
`define SG_ERR_EXT_TRIP        8'h0C
`define SG_ERR_START_GUARD     8'h0D
`define SG_SETTLE_COUNT        2'h2
`endif

// ### design/start_guard_pkg.sv
/*
  types for the start guard.
  assumes nothing of its surroundings.
*/
package start_guard_pkg;
  typedef enum logic [1:0] {
    POWERUP,
    STOPPED,
    RUNNING,
    TRIPPED
  } guard_state_t;
endpackage

// ### design/unattended_start_guard.sv
/*
  start protection for a motor drive: decides at power-up whether an already
  present run command may start the output, latches the start-guard trip.
  assumes terminal inputs are asynchronous pins; keypad reset is a same-clock pulse.
*/
// How it works
// - guard off, run present at power-up: output starts right away
// - guard on, run present at power-up: withhold output, trip, code, alarm
// - active guard input blocks a run command present at power-up
// - inactive guard input resumes the run command held before power loss
// - dropping run clears trip; reasserting run then runs again
// - fault-clear terminal or keypad reset both clear the alarm
// - reset-clear with run still present restarts output immediately
// - after undervoltage trip cleared by fault-clear pulse, guard still applies
// - guard function assignable to any of eight terminal selections
// - cleared external trip under guard waits for run edge or reset
`timescale 1ns/1ps
`include "start_guard_params.svh"
module unattended_start_guard #(
  parameter int TERMINALS = `SG_TERMINAL_COUNT
) (
  input  wire logic                          core_clk,
  input  wire logic                          resetn,
  input  wire logic [TERMINALS-1:0]          terminalPins,
  input  wire logic [`SG_OPTION_WIDTH-1:0]   terminalFunction [TERMINALS],
  input  wire logic                          runCommand,
  input  wire logic                          faultClearTerminal,
  input  wire logic                          keypadReset,
  input  wire logic                          underVoltage,
  output logic                               outputEnable,
  output logic                               alarm,
  output logic [`SG_ERR_WIDTH-1:0]           errorCode
);
  logic [TERMINALS-1:0] pinMeta, pinSync;
  logic [TERMINALS-1:0] next_pinMeta, next_pinSync;
  logic [2:0]           ctlMeta, ctlSync;
  logic [2:0]           next_ctlMeta, next_ctlSync;
  logic                 runPrev, clearPrev;
  logic                 next_runPrev, next_clearPrev;
  logic [1:0]           settle, next_settle;
  logic                 armed;
  start_guard_pkg::guard_state_t state, next_state;
  logic                          extLatched, next_extLatched;
  logic                          uvLatched, next_uvLatched;
  logic                          next_outputEnable, next_alarm;
  logic [`SG_ERR_WIDTH-1:0]      next_errorCode;

  // any terminal can carry a given function
  function automatic logic pickFunction(input logic [TERMINALS-1:0] pins,
                                        input logic [`SG_OPTION_WIDTH-1:0] want);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < TERMINALS; i++) begin
      if (terminalFunction[i] == want && pins[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // two flip-flops on every pin before any logic reads it
  always_comb begin
    next_pinMeta   = terminalPins;
    next_pinSync   = pinMeta;
    next_ctlMeta   = {underVoltage, faultClearTerminal, runCommand};
    next_ctlSync   = ctlMeta;
    next_runPrev   = ctlSync[0];
    next_clearPrev = ctlSync[1];
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pinMeta   <= '0;
      pinSync   <= '0;
      ctlMeta   <= 3'h0;
      ctlSync   <= 3'h0;
      runPrev   <= 1'b0;
      clearPrev <= 1'b0;
    end else begin
      pinMeta   <= next_pinMeta;
      pinSync   <= next_pinSync;
      ctlMeta   <= next_ctlMeta;
      ctlSync   <= next_ctlSync;
      runPrev   <= next_runPrev;
      clearPrev <= next_clearPrev;
    end
  end

  // edges the synchronisers need after reset before they carry real levels
  always_comb begin
    if (settle == `SG_SETTLE_COUNT) begin
      next_settle = settle;
    end else begin
      next_settle = 2'(settle + 2'h1);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      settle <= 2'h0;
    end else begin
      settle <= next_settle;
    end
  end

  logic runNow, clearNow, uvNow, guardOn, extOn, runRise, clearReq;
  always_comb begin
    runNow   = ctlSync[0];
    clearNow = ctlSync[1];
    uvNow    = ctlSync[2];
    guardOn  = pickFunction(pinSync, `SG_GUARD_OPTION);
    extOn    = pickFunction(pinSync, `SG_EXT_TRIP_OPTION);
    runRise  = runNow && !runPrev;
    // clear acts on the terminal's release, like a reset pulse; keypad is direct
    clearReq = (clearPrev && !clearNow) || keypadReset;
  end

  // one code at a time: the start-guard trip outranks a latched trip
  function automatic logic [`SG_ERR_WIDTH-1:0] codeFor(input logic guardTrip,
                                                        input logic extTrip,
                                                        input logic uvTrip);
    logic [`SG_ERR_WIDTH-1:0] code;
    if (guardTrip) begin
      code = `SG_ERR_START_GUARD;
    end else if (extTrip) begin
      code = `SG_ERR_EXT_TRIP;
    end else if (uvTrip) begin
      code = `SG_ERR_UNDERVOLTAGE;
    end else begin
      code = `SG_ERR_NONE;
    end
    return code;
  endfunction

  always_comb begin
    armed           = (settle == `SG_SETTLE_COUNT);
    next_state      = state;
    next_extLatched = extLatched || extOn;
    next_uvLatched  = uvLatched || uvNow;
    case (state)
      // decided once, on the first armed edge, from settled pin levels
      start_guard_pkg::POWERUP: begin
        if (runNow && guardOn) begin
          next_state = start_guard_pkg::TRIPPED;
        end else if (runNow) begin
          next_state = start_guard_pkg::RUNNING;
        end else begin
          next_state = start_guard_pkg::STOPPED;
        end
      end
      start_guard_pkg::STOPPED: begin
        if (next_extLatched || next_uvLatched) begin
          if (clearReq) begin
            // clear reloads the live levels, so a trip still present wins
            next_extLatched = extOn;
            next_uvLatched  = uvNow;
            // a run still held after clearing a trip is a fresh unattended start
            if (runNow && guardOn) begin
              next_state = start_guard_pkg::TRIPPED;
            end
          end
        end else if (runRise || (runNow && !guardOn)) begin
          next_state = start_guard_pkg::RUNNING;
        end
      end
      start_guard_pkg::RUNNING: begin
        if (!runNow) begin
          next_state = start_guard_pkg::STOPPED;
        end
      end
      start_guard_pkg::TRIPPED: begin
        if (clearReq) begin
          next_extLatched = extOn;
          next_uvLatched  = uvNow;
          if (runNow) begin
            next_state = start_guard_pkg::RUNNING;
          end else begin
            next_state = start_guard_pkg::STOPPED;
          end
        end else if (!runNow) begin
          next_state = start_guard_pkg::STOPPED;
        end
        // otherwise stay latched whatever else happens
      end
      default: begin
        next_state = start_guard_pkg::POWERUP;
      end
    endcase
    // a latched supply or external trip keeps the output off
    if ((next_extLatched || next_uvLatched) &&
        next_state == start_guard_pkg::RUNNING) begin
      next_state = start_guard_pkg::STOPPED;
    end
    // nothing moves until the synchronisers carry real pin levels
    if (!armed) begin
      next_state      = state;
      next_extLatched = extLatched;
      next_uvLatched  = uvLatched;
    end
    next_outputEnable = (next_state == start_guard_pkg::RUNNING);
    next_alarm        = (next_state == start_guard_pkg::TRIPPED) ||
                        next_extLatched || next_uvLatched;
    next_errorCode    = codeFor(next_state == start_guard_pkg::TRIPPED,
                                next_extLatched, next_uvLatched);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state        <= start_guard_pkg::POWERUP;
      extLatched   <= 1'b0;
      uvLatched    <= 1'b0;
      outputEnable <= 1'b0;
      alarm        <= 1'b0;
      errorCode    <= `SG_ERR_NONE;
    end else begin
      state        <= next_state;
      extLatched   <= next_extLatched;
      uvLatched    <= next_uvLatched;
      outputEnable <= next_outputEnable;
      alarm        <= next_alarm;
      errorCode    <= next_errorCode;
    end
  end
endmodule

// ### verif/sg_operator_model.sv
/* operator model: terminal pins, run, fault clear, keypad key, supply.
   assumes the bench calls its tasks; it drives after falling edges. */
`timescale 1ns/1ps
module sg_operator_model (
  input  wire logic       core_clk,
  output logic [7:0]      terminalPins,
  output logic            runCommand,
  output logic            faultClearTerminal,
  output logic            keypadReset,
  output logic            underVoltage
);
  initial {terminalPins, runCommand, faultClearTerminal, keypadReset, underVoltage} = '0;
  task automatic set(input logic [7:0] p, input logic r, input logic u);
    @(negedge core_clk);
    {terminalPins, runCommand, underVoltage} = {p, r, u};
  endtask
  // one clock wide: a held key would clear twice
  task automatic key();
    @(negedge core_clk) keypadReset = 1'h1;
    @(negedge core_clk) keypadReset = 1'h0;
  endtask
  // clearing acts on release, so hold it on first
  task automatic clr();
    @(negedge core_clk) faultClearTerminal = 1'h1;
    repeat (4) @(negedge core_clk);
    faultClearTerminal = 1'h0;
  endtask
endmodule

// ### verif/start_guard_properties.sv
/* start guard port properties.
   assumes a bind from the bench; pins reach outputs three edges later. */
`timescale 1ns/1ps
`include "start_guard_params.svh"
module start_guard_properties (
  input wire logic                     core_clk,
  input wire logic                     resetn,
  input wire logic                     runCommand,
  input wire logic                     faultClearTerminal,
  input wire logic                     keypadReset,
  input wire logic                     underVoltage,
  input wire logic                     outputEnable,
  input wire logic                     alarm,
  input wire logic [`SG_ERR_WIDTH-1:0] errorCode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire trip = errorCode == `SG_ERR_START_GUARD;
  sequence keyOnTrip;
    (runCommand && !underVoltage)[*4] ##0 (trip && keypadReset);
  endsequence
  AST_TRIP_STOPS: assert property (trip |-> alarm && !outputEnable)
    else $error("trip with output on");
  AST_ALARM_CODE: assert property (alarm == (errorCode != `SG_ERR_NONE))
    else $error("alarm and code disagree");
  AST_ALARM_STOPS: assert property (alarm |-> !outputEnable)
    else $error("alarm with output on");
  AST_KEY_CLEARS: assert property (keyOnTrip |=> !alarm)
    else $error("key did not clear");
  AST_KEY_RESTART: assert property (keyOnTrip |=> outputEnable)
    else $error("key did not restart");
  property tripHeld;
    (runCommand && !faultClearTerminal && !underVoltage)[*5]
      ##0 (trip && !keypadReset) |=> trip;
  endproperty
  AST_TRIP_LATCHED: assert property (tripHeld)
    else $error("trip dropped");
  AST_DROP_CLEARS: assert property ((!runCommand)[*5] |-> !trip)
    else $error("run drop kept trip");
  AST_START_NEEDS_RUN: assert property ($rose(outputEnable) |-> $past(runCommand, 3))
    else $error("start without run");
  cover property ($rose(alarm));
  cover property (trip && keypadReset);
  cover property ($rose(outputEnable));
endmodule

// ### verif/unattended_start_guard_bench.sv
/* bench for the start guard: power-up, trips, clearing and restart.
   assumes the operator model drives every terminal input. */
`timescale 1ns/1ps
`include "start_guard_params.svh"
module unattended_start_guard_bench;
  logic       core_clk;
  logic       resetn;
  logic [7:0] fn [8];
  logic [7:0] terminalPins;
  logic       runCommand, faultClearTerminal, keypadReset, underVoltage;
  logic       outputEnable, alarm;
  logic [7:0] errorCode;
  int         mismatches = 0;
  int         tests_run = 0;
  sg_operator_model op (.core_clk, .terminalPins, .runCommand, .faultClearTerminal,
    .keypadReset, .underVoltage);
  unattended_start_guard DUT (.core_clk, .resetn, .terminalPins, .terminalFunction(fn),
    .runCommand, .faultClearTerminal, .keypadReset, .underVoltage, .outputEnable, .alarm,
    .errorCode);
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  wire logic [9:0] status = {outputEnable, alarm, errorCode};
  task automatic check(input logic [9:0] seen, input logic [9:0] want);
    tests_run++;
    if (seen !== want) begin
      mismatches++;
      $display("Error at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  // inputs held steady through reset so the power-up decision is clean
  task automatic powerup(input int g, input logic grd, input logic run);
    resetn = 1'h0;
    foreach (fn[i]) fn[i] = (i == g) ? `SG_GUARD_OPTION : 8'h00;
    op.set(8'(grd) << g, run, 1'h0);
    repeat (16) @(negedge core_clk);
    resetn = 1'h1;
    repeat (8) @(negedge core_clk);
  endtask
  task automatic t_pins();
    powerup(0, 1'h0, 1'h1);
    check(status, {2'h2, `SG_ERR_NONE});
    for (int g = 0; g < 8; g++) begin
      powerup(g, 1'h1, 1'h1);
      check(status, {2'h1, `SG_ERR_START_GUARD});
    end
    repeat (20) @(negedge core_clk);
    check(status, {2'h1, `SG_ERR_START_GUARD});
    op.set(8'h80, 1'h0, 1'h0);
    repeat (5) @(negedge core_clk);
    check(status, {2'h0, `SG_ERR_NONE});
    op.set(8'h80, 1'h1, 1'h0);
    repeat (5) @(negedge core_clk);
    check(status, {2'h2, `SG_ERR_NONE});
  endtask
  task automatic t_clears();
    powerup(5, 1'h1, 1'h1);
    op.key();
    check(status, {2'h2, `SG_ERR_NONE});
    powerup(5, 1'h1, 1'h1);
    op.clr();
    repeat (4) @(negedge core_clk);
    check(status, {2'h2, `SG_ERR_NONE});
  endtask
  task automatic t_trips();
    powerup(0, 1'h0, 1'h1);
    op.set(8'h01, 1'h1, 1'h1);
    repeat (5) @(negedge core_clk);
    check(status, {2'h1, `SG_ERR_UNDERVOLTAGE});
    op.set(8'h01, 1'h1, 1'h0);
    op.clr();
    repeat (4) @(negedge core_clk);
    check(status, {2'h1, `SG_ERR_START_GUARD});
    fn[1] = `SG_EXT_TRIP_OPTION;
    op.key();
    op.set(8'h03, 1'h1, 1'h0);
    repeat (5) @(negedge core_clk);
    check(status, {2'h1, `SG_ERR_EXT_TRIP});
    op.set(8'h01, 1'h1, 1'h0);
    // the released trip pin needs two edges through its synchroniser
    repeat (2) @(negedge core_clk);
    op.key();
    repeat (4) @(negedge core_clk);
    check(status, {2'h1, `SG_ERR_START_GUARD});
  endtask
  // guard off: a cleared supply trip lets the held run resume
  task automatic t_resume();
    powerup(2, 1'h0, 1'h1);
    op.set(8'h00, 1'h1, 1'h1);
    repeat (5) @(negedge core_clk);
    check(status, {2'h1, `SG_ERR_UNDERVOLTAGE});
    op.set(8'h00, 1'h1, 1'h0);
    repeat (2) @(negedge core_clk);
    op.key();
    repeat (4) @(negedge core_clk);
    check(status, {2'h2, `SG_ERR_NONE});
  endtask
  task automatic stop_test();
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    t_pins();
    t_clears();
    t_trips();
    t_resume();
    stop_test();
  end
  // the whole run takes under 10 us
  initial begin
    #100us;
    mismatches++;
    stop_test();
  end
endmodule
bind unattended_start_guard start_guard_properties chk (
  .core_clk           (core_clk),
  .resetn             (resetn),
  .runCommand         (runCommand),
  .faultClearTerminal (faultClearTerminal),
  .keypadReset        (keypadReset),
  .underVoltage       (underVoltage),
  .outputEnable       (outputEnable),
  .alarm              (alarm),
  .errorCode          (errorCode)
);
